// File: src/ebz_defs.vh
`ifndef EBZ_DEFS_VH
`define EBZ_DEFS_VH

// Register word indices; byte address is four times the index
`define EBZ_IDX_ZONE0      14'h0b20
`define EBZ_IDX_ZONE6      14'h0b2c
`define EBZ_IDX_ZONE7      14'h0b2e
`define EBZ_IDX_CONFIG     14'h0b34
`define EBZ_IDX_CONFIG1    14'h0b32
`define EBZ_IDX_BANK       14'h0b38
`define EBZ_IDX_REVISION   14'h0b3a
`define EBZ_IDX_SOFT_RST   14'h083d

// Zone timing field positions
`define EBZ_X2_BIT         22
`define EBZ_WIDTH_HI       17
`define EBZ_WIDTH_LO       16
`define EBZ_RDY_ASYNC_BIT  15
`define EBZ_RDY_USE_BIT    14
`define EBZ_RD_LEAD_HI     13
`define EBZ_RD_LEAD_LO     12
`define EBZ_RD_ACT_HI      11
`define EBZ_RD_ACT_LO      9
`define EBZ_RD_TRAIL_HI    8
`define EBZ_RD_TRAIL_LO    7
`define EBZ_WR_LEAD_HI     6
`define EBZ_WR_LEAD_LO     5
`define EBZ_WR_ACT_HI      4
`define EBZ_WR_ACT_LO      2
`define EBZ_WR_TRAIL_HI    1
`define EBZ_WR_TRAIL_LO    0

// Bus width codes
`define EBZ_WIDTH_32       2'b01
`define EBZ_WIDTH_16       2'b11

// Writable bits and reset values
`define EBZ_TIMING_WMASK   32'h0043ffff
`define EBZ_TIMING_RESET   32'h0043ffff
`define EBZ_CONFIG_RESET   32'h00000000
`define EBZ_BANK_RESET     16'h0000
`define EBZ_SOFT_RST_RESET 16'h0000
// Arbitrary revision value, names no part
`define EBZ_REVISION_VALUE 16'h0001

`endif

// File: src/ebz_zone_sequencer.v
`timescale 1ns/1ns
`include "ebz_defs.vh"

module ebz_zone_sequencer
(
    // Clock and reset
    input  wire        sys_clk_in,
    input  wire        resetn_in,
    // Access request
    input  wire        start_in,
    input  wire        write_in,
    input  wire [31:0] timing_in,
    input  wire        ready_in,
    // Access status
    output wire        busy_out,
    output wire [2:0]  phase_out,
    output wire        done_out,
    output wire        wide_out
);

    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_LEAD  = 4'b0010;
    localparam [3:0] ST_ACT   = 4'b0100;
    localparam [3:0] ST_TRAIL = 4'b1000;

    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [4:0] cnt_q;
    reg [4:0] cnt_d;
    reg [4:0] act_q;
    reg [4:0] trail_q;
    reg       use_rdy_q;
    reg       done_q;
    reg       wide_q;
    reg       busy_q;

    // Scale a wait count by one or two
    function [4:0] scale;
        input [2:0] val;
        input       dbl;
        begin
            scale = dbl ? {1'b0, val, 1'b0} : {2'b00, val};
        end
    endfunction

    wire       x2     = timing_in[`EBZ_X2_BIT];
    wire [2:0] lead   = write_in ? {1'b0, timing_in[`EBZ_WR_LEAD_HI:`EBZ_WR_LEAD_LO]}
                                 : {1'b0, timing_in[`EBZ_RD_LEAD_HI:`EBZ_RD_LEAD_LO]};
    wire [2:0] active = write_in ? timing_in[`EBZ_WR_ACT_HI:`EBZ_WR_ACT_LO]
                                 : timing_in[`EBZ_RD_ACT_HI:`EBZ_RD_ACT_LO];
    wire [2:0] trail  = write_in ? {1'b0, timing_in[`EBZ_WR_TRAIL_HI:`EBZ_WR_TRAIL_LO]}
                                 : {1'b0, timing_in[`EBZ_RD_TRAIL_HI:`EBZ_RD_TRAIL_LO]};

    // Phase sequencing; lead and active counts of 0 still take one cycle, a trail count of 0 skips trail, nothing is corrected
    always @*
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_IDLE:
            begin
                if (start_in)
                begin
                    state_d = ST_LEAD;
                    // RL1 - doubled lead count
                    cnt_d   = scale(lead, x2);
                end
            end
            ST_LEAD:
            begin
                if (cnt_q <= 5'h01)
                begin
                    state_d = ST_ACT;
                    cnt_d   = act_q;
                end
                else
                    cnt_d = cnt_q - 5'h01;
            end
            ST_ACT:
            begin
                if (cnt_q <= 5'h01)
                begin
                    // RL9 - ready stretches active
                    if (!(use_rdy_q && !ready_in))
                    begin
                        state_d = (trail_q == 5'h00) ? ST_IDLE : ST_TRAIL;
                        cnt_d   = trail_q;
                    end
                end
                else
                    cnt_d = cnt_q - 5'h01;
            end
            ST_TRAIL:
            begin
                if (cnt_q <= 5'h01)
                    state_d = ST_IDLE;
                else
                    cnt_d = cnt_q - 5'h01;
            end
            default:
            begin
                state_d = ST_IDLE;
                cnt_d   = 5'h00;
            end
        endcase
    end

    // Latch zone settings at start so a later rewrite cannot disturb it
    always @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_q   <= ST_IDLE;
            cnt_q     <= 5'h00;
            act_q     <= 5'h01;
            trail_q   <= 5'h00;
            use_rdy_q <= 1'b0;
            done_q    <= 1'b0;
            wide_q    <= 1'b0;
            busy_q    <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            done_q  <= (state_q != ST_IDLE) && (state_d == ST_IDLE);
            busy_q  <= (state_d != ST_IDLE); // Own flop, no gate on the port
            if (state_q == ST_IDLE && start_in)
            begin
                // RL1 - doubled active and trail
                act_q     <= scale(active, x2) + 5'h01;
                trail_q   <= scale(trail, x2);
                // RL8 - ready used or ignored
                use_rdy_q <= timing_in[`EBZ_RDY_USE_BIT];
                // RL3 - code 01 selects 32 lines
                wide_q    <= (timing_in[`EBZ_WIDTH_HI:`EBZ_WIDTH_LO] == `EBZ_WIDTH_32);
            end
        end
    end

    assign busy_out  = busy_q;
    assign phase_out = state_q[3:1];
    assign done_out  = done_q;
    assign wide_out  = wide_q;

endmodule // ebz_zone_sequencer

// File: src/ebz_config_regs.v
`timescale 1ns/1ns
`include "ebz_defs.vh"

// Behaviour
// RL1 - Scale bit doubles all zone wait counts
// RL2 - Scale bit resets to one
// RL3 - Width code 01 uses 32 lines
// RL4 - Width code 11 uses 16, default
// RL5 - Software writes only 01 or 11
// RL6 - Mode bit selects sync or async ready
// RL7 - Mode bit ignored when ready unused
// RL8 - Ready-use bit enables ready sampling
// RL9 - Ready lengthens active phase when enabled
// RL10 - Writes only while protected unlock active
// RL11 - Reprogram from outside the zone
// RL12 - Illegal settings applied without checks
// RL13 - Separate timing registers, zones 0/6/7
// RL14 - First config slot reserved, unused
// RL15 - Two words or one word per register
// RL16 - Reserved timing bits read zero
module ebz_config_regs
(
    // Clock and reset
    input  wire        sys_clk_in,
    input  wire        resetn_in,
    // APB slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [15:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire        pready_out,
    output wire        pslverr_out,
    // Protection
    input  wire        protected_write_unlock_in,
    // Zone access request
    input  wire        acc_start_in,
    input  wire [2:0]  acc_zone_in,
    input  wire        acc_write_in,
    input  wire        ext_ready_in,
    // Zone access status
    output wire        acc_busy_out,
    output wire [2:0]  acc_phase_out,
    output wire        acc_done_out,
    output wire        acc_wide_out,
    // Register contents for the rest of the interface
    output wire [31:0] interface_config_out,
    output wire [15:0] bank_switch_control_out,
    output wire [15:0] interface_soft_reset_out
);

    reg  [31:0] zone_timing_q [0:2];
    reg  [31:0] config_q;
    reg  [15:0] bank_q;
    reg  [15:0] soft_rst_q;
    reg  [31:0] prdata_q;
    reg         pready_q;
    reg         pslverr_q;
    reg  [31:0] rd_word;
    reg         rd_hit;
    reg         rdy_s1_q;
    reg         rdy_s2_q;
    reg         rdy_s3_q;
    reg  [31:0] sel_timing;
    reg         rdy_async_q;

    wire [13:0] idx      = paddr_in[15:2];
    wire        aligned  = (paddr_in[1:0] == 2'b00);
    wire        setup    = psel_in && !penable_in;
    wire        wr_fire  = psel_in && penable_in && pready_q && pwrite_in && !pslverr_q;
    // RL10 - writes gated by unlock
    wire        wr_ok    = wr_fire && protected_write_unlock_in;

    // Storage slot to timing register word index
    function [13:0] zone_index;
        input integer slot;
        begin
            case (slot)
                0:       zone_index = `EBZ_IDX_ZONE0;
                1:       zone_index = `EBZ_IDX_ZONE6;
                default: zone_index = `EBZ_IDX_ZONE7;
            endcase
        end
    endfunction

    // Per-zone timing registers
    genvar z;
    generate
        for (z = 0; z < 3; z = z + 1)
        begin : g_zone
            wire lo_hit = wr_ok && (idx == zone_index(z));
            wire hi_hit = wr_ok && (idx == zone_index(z) + 14'h0001);
            always @(posedge sys_clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    // RL2 - RL4 - RL6 - doubled, 16-bit, async defaults
                    zone_timing_q[z] <= `EBZ_TIMING_RESET;
                // RL13 - only this zone changes
                else if (lo_hit)
                    // RL16 - reserved bits masked; RL12 - no checks
                    zone_timing_q[z] <= pwdata_in & `EBZ_TIMING_WMASK;
                else if (hi_hit)
                    // RL15 - second word is upper half
                    zone_timing_q[z] <= {pwdata_in[15:0], zone_timing_q[z][15:0]}
                                        & `EBZ_TIMING_WMASK;
            end
        end
    endgenerate

    // Other writable registers
    always @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            config_q   <= `EBZ_CONFIG_RESET;
            bank_q     <= `EBZ_BANK_RESET;
            soft_rst_q <= `EBZ_SOFT_RST_RESET;
        end
        else if (wr_ok)
        begin
            // RL15 - config spans two words
            if (idx == `EBZ_IDX_CONFIG)
                config_q <= pwdata_in;
            if (idx == `EBZ_IDX_CONFIG + 14'h0001)
                config_q <= {pwdata_in[15:0], config_q[15:0]};
            if (idx == `EBZ_IDX_BANK)
                bank_q <= pwdata_in[15:0];
            if (idx == `EBZ_IDX_SOFT_RST)
                soft_rst_q <= pwdata_in[15:0];
        end
    end

    // Read decode; unknown index answers with an error
    always @*
    begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        if (idx == `EBZ_IDX_ZONE0)
            rd_word = zone_timing_q[0];
        else if (idx == `EBZ_IDX_ZONE0 + 14'h0001)
            rd_word = {16'h0000, zone_timing_q[0][31:16]};
        else if (idx == `EBZ_IDX_ZONE6)
            rd_word = zone_timing_q[1];
        else if (idx == `EBZ_IDX_ZONE6 + 14'h0001)
            rd_word = {16'h0000, zone_timing_q[1][31:16]};
        else if (idx == `EBZ_IDX_ZONE7)
            rd_word = zone_timing_q[2];
        else if (idx == `EBZ_IDX_ZONE7 + 14'h0001)
            rd_word = {16'h0000, zone_timing_q[2][31:16]};
        // RL14 - old config slot reads zero
        else if (idx == `EBZ_IDX_CONFIG1 || idx == `EBZ_IDX_CONFIG1 + 14'h0001)
            rd_word = 32'h00000000;
        else if (idx == `EBZ_IDX_CONFIG)
            rd_word = config_q;
        else if (idx == `EBZ_IDX_CONFIG + 14'h0001)
            rd_word = {16'h0000, config_q[31:16]};
        else if (idx == `EBZ_IDX_BANK)
            rd_word = {16'h0000, bank_q};
        else if (idx == `EBZ_IDX_REVISION)
            rd_word = {16'h0000, `EBZ_REVISION_VALUE};
        else if (idx == `EBZ_IDX_SOFT_RST)
            rd_word = {16'h0000, soft_rst_q};
        else
            rd_hit = 1'b0;
        if (!aligned)
        begin
            rd_word = 32'h00000000;
            rd_hit  = 1'b0;
        end
    end

    // One wait-free access cycle; answer prepared during setup
    always @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup && !rd_hit;
            if (setup && !pwrite_in)
                prdata_q <= rd_word;
        end
    end

    // Ready pin synchroniser; third stage is the async-mode settle stage
    always @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
            rdy_s3_q <= 1'b0;
        end
        else
        begin
            rdy_s1_q <= ext_ready_in;
            rdy_s2_q <= rdy_s1_q;
            rdy_s3_q <= rdy_s2_q;
        end
    end

    // Timing word of the zone being accessed; zones 1 to 5 have no register
    always @*
    begin
        case (acc_zone_in)
            3'h6:    sel_timing = zone_timing_q[1];
            3'h7:    sel_timing = zone_timing_q[2];
            default: sel_timing = zone_timing_q[0];
        endcase
    end

    // Ready mode taken at access start; a zone change mid-access cannot switch stages
    always @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rdy_async_q <= 1'b1;
        else if (acc_start_in && !acc_busy_out)
            rdy_async_q <= sel_timing[`EBZ_RDY_ASYNC_BIT];
    end

    // RL6 - async adds one settle stage; RL7 - unused when ready off
    wire rdy_sel = rdy_async_q ? rdy_s3_q : rdy_s2_q;

    ebz_zone_sequencer u_seq
    (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .start_in   (acc_start_in),
        .write_in   (acc_write_in),
        .timing_in  (sel_timing),
        .ready_in   (rdy_sel),
        .busy_out   (acc_busy_out),
        .phase_out  (acc_phase_out),
        .done_out   (acc_done_out),
        .wide_out   (acc_wide_out)
    );

    assign prdata_out               = prdata_q;
    assign pready_out               = pready_q;
    assign pslverr_out              = pslverr_q;
    assign interface_config_out     = config_q;
    assign bank_switch_control_out  = bank_q;
    assign interface_soft_reset_out = soft_rst_q;

endmodule // ebz_config_regs

// File: test/ebz_config_regs_props.sv
`timescale 1ns/1ns
`include "ebz_defs.vh"

module ebz_config_regs_props
(
    // Clock and reset
    input wire        sys_clk_in,
    input wire        resetn_in,
    // APB slave
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [15:0] paddr_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    input wire        protected_write_unlock_in,
    // Zone access status
    input wire        acc_busy_out,
    input wire [2:0]  acc_phase_out,
    input wire        acc_done_out,
    // Register contents
    input wire [31:0] interface_config_out,
    input wire [15:0] bank_switch_control_out
);
    // Commit edge of a write and answer cycle of a read
    wire wr_go = psel_in && penable_in && pready_out && pwrite_in;
    wire rd_go = pready_out && !pwrite_in;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    chk_ready_once: assert property (
        psel_in && !penable_in |=> pready_out ##1 !pready_out)
        else $error("Ready not one cycle after setup");
    chk_locked_hold: assert property (
        psel_in && penable_in && pwrite_in && !protected_write_unlock_in |=>
            $stable(interface_config_out) && $stable(bank_switch_control_out))
        else $error("Locked write changed a register");
    chk_config_isolated: assert property (
        wr_go && !(paddr_in[15:2] inside {`EBZ_IDX_CONFIG, `EBZ_IDX_CONFIG + 14'h1})
            |=> $stable(interface_config_out))
        else $error("Config changed by another write");
    chk_revision_read: assert property (
        rd_go && paddr_in == {`EBZ_IDX_REVISION, 2'h0} |->
            prdata_out == {16'h0000, `EBZ_REVISION_VALUE} && !pslverr_out)
        else $error("Revision read wrong");
    chk_reserved_zero: assert property (
        rd_go && paddr_in[1:0] == 2'h0 && paddr_in[15:2] inside
            {`EBZ_IDX_ZONE0, `EBZ_IDX_ZONE6, `EBZ_IDX_ZONE7} |->
            prdata_out[31:23] == 9'h000 && prdata_out[21:18] == 4'h0)
        else $error("Reserved timing bits not zero");
    chk_misaligned_err: assert property (
        pready_out && paddr_in[1:0] != 2'h0 |-> pslverr_out)
        else $error("Misaligned access without error");
    chk_lead_first: assert property (
        $rose(acc_busy_out) |-> acc_phase_out == 3'h1)
        else $error("Access did not open with lead");
    chk_lead_to_active: assert property (
        acc_phase_out == 3'h1 ##1 acc_phase_out != 3'h1 |-> acc_phase_out == 3'h2)
        else $error("Lead not followed by active");
    chk_phase_onehot: assert property (
        acc_busy_out |-> $onehot(acc_phase_out))
        else $error("Phase not one-hot while busy");
    chk_done_after: assert property (
        $fell(acc_busy_out) |-> ##[0:1] acc_done_out)
        else $error("Done missing after access");
endmodule // ebz_config_regs_props

bind ebz_config_regs ebz_config_regs_props u_props (.*);

// File: test/tb_ebz_config_regs.sv
`timescale 1ns/1ns
`include "ebz_defs.vh"

module tb_ebz_config_regs;
    // Word indices; zones, bank and revision first for random writes
    localparam int Z0 = `EBZ_IDX_ZONE0;
    localparam int Z6 = `EBZ_IDX_ZONE6;
    localparam int Z7 = `EBZ_IDX_ZONE7;
    localparam int CF = `EBZ_IDX_CONFIG;
    localparam int C1 = `EBZ_IDX_CONFIG1;
    localparam int IX[14] = '{Z0, Z0 + 1, Z6, Z6 + 1, Z7, Z7 + 1, `EBZ_IDX_BANK,
        `EBZ_IDX_REVISION, CF, CF + 1, C1, C1 + 1, `EBZ_IDX_SOFT_RST, 14'h0b22};

    logic        clk    = 1'b0;
    logic        rstn   = 1'b0;
    logic        psel   = 1'b0;
    logic        pen    = 1'b0;
    logic        pwr    = 1'b0;
    logic        lk     = 1'b0;
    logic        start  = 1'b0;
    logic        accw   = 1'b0;
    logic        rdy    = 1'b0;
    logic [2:0]  zone   = 3'h0;
    logic [15:0] paddr  = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rs     = 32'h000143b2;
    logic [31:0] prdata;
    logic [2:0]  phase;
    logic        pready, perr, busy, done, wide;
    logic [31:0] cfg;
    logic [15:0] bank, srst;
    logic [31:0] m[int];
    int          mismatches = 0;
    int          checked    = 0;
    int          cycles     = 0;
    int          ns, na;

    always #5 clk = ~clk;

    ebz_config_regs dut
    (
        .sys_clk_in(clk), .resetn_in(rstn), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(perr), .protected_write_unlock_in(lk),
        .acc_start_in(start), .acc_zone_in(zone), .acc_write_in(accw),
        .ext_ready_in(rdy), .acc_busy_out(busy), .acc_phase_out(phase),
        .acc_done_out(done), .acc_wide_out(wide), .interface_config_out(cfg),
        .bank_switch_control_out(bank), .interface_soft_reset_out(srst)
    );

    // Seed-driven pseudo-random source
    function logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Access length in cycles: lead never below one
    function int cyc(input logic [31:0] t, input logic w);
        int x, l, a, r;
        x = t[22];
        l = (w ? t[6:5] : t[13:12]) << x;
        a = w ? t[4:2] : t[11:9];
        r = w ? t[1:0] : t[8:7];
        cyc = (l > 0 ? l : 1) + (a << x) + 1 + (r << x);
    endfunction

    // Expected {error, data}; upper words show bits 31:16
    function logic [32:0] expv(input int i);
        if (m.exists(i))
            return {1'b0, m[i]};
        if (i - 1 inside {Z0, Z6, Z7, CF, C1})
            return {17'h0, m[i - 1][31:16]};
        return {1'b1, 32'h0};
    endfunction

    task chk(input logic [32:0] s, input logic [32:0] x);
        checked++;
        if (s !== x)
        begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, s, x);
        end
    endtask

    // One APB transfer, held until ready, then one idle cycle
    task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        logic [32:0] x;
        int          i, n;
        i = a[15:2];
        n = 0;
        x = (a[1:0] != 2'h0) ? {1'b1, 32'h0} : expv(i);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk(perr, x[32]);
        if (!w)
            chk(prdata, x[31:0]);
        else if (lk && !x[32])
        begin
            if (i inside {Z0, Z6, Z7})
                m[i] = d & `EBZ_TIMING_WMASK;
            if (i - 1 inside {Z0, Z6, Z7})
                m[i - 1][31:16] = d[15:0] & 16'(`EBZ_TIMING_WMASK >> 16);
            if (i inside {`EBZ_IDX_BANK, `EBZ_IDX_SOFT_RST})
                m[i] = {16'h0, d[15:0]};
            if (i == CF)
                m[i] = d;
            if (i == CF + 1)
                m[CF][31:16] = d[15:0];
        end
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task scan;
        for (int k = 0; k < 14; k++)
            xfer(1'b0, 16'(IX[k] * 4), 32'h0);
    endtask

    // Zone access; ready rises r cycles after start, busy cycles counted
    task acc(input logic [2:0] z, input logic w, input int r, output int n);
        n = 0;
        zone <= z;
        accw <= w;
        start <= 1'b1;
        rdy <= 1'b0;
        @(posedge clk);
        start <= 1'b0;
        for (int i = 1; i < 300 && (i < 3 || busy === 1'b1); i++)
        begin
            @(posedge clk);
            rdy <= (i >= r);
            if (busy === 1'b1)
                n++;
        end
        @(posedge clk);
    endtask

    task finish_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard, far above the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            finish_test;
        end
    end

    // Main sequence
    initial
    begin
        m[Z0] = `EBZ_TIMING_RESET;
        m[Z6] = `EBZ_TIMING_RESET;
        m[Z7] = `EBZ_TIMING_RESET;
        m[CF] = 32'h0;
        m[C1] = 32'h0;
        m[`EBZ_IDX_BANK] = 32'h0;
        m[`EBZ_IDX_SOFT_RST] = 32'h0;
        m[`EBZ_IDX_REVISION] = {16'h0, `EBZ_REVISION_VALUE};
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        // Reset values, reserved slot, unmapped and misaligned places
        scan;
        xfer(1'b0, 16'(Z0 * 4 + 2), 32'h0);
        // Random data, unlock and targets
        repeat (16)
        begin
            rs = lfsr(rs);
            lk <= rs[9];
            xfer(1'b1, 16'(IX[rs[6:4]] * 4), rs | 32'h00010001);
        end
        xfer(1'b1, 16'h0b22 * 4, rs);
        scan;
        // Config words, reserved slot and soft reset; locked write first
        lk <= 1'b0;
        xfer(1'b1, 16'(CF * 4), 32'h5a5a0f0f);
        lk <= 1'b1;
        xfer(1'b1, 16'(CF * 4), rs);
        xfer(1'b1, 16'(CF * 4 + 4), 32'h0000c3a5);
        xfer(1'b1, 16'(C1 * 4), rs);
        xfer(1'b1, 16'(`EBZ_IDX_SOFT_RST * 4), rs);
        scan;
        chk(cfg, m[CF]);
        chk(bank, m[`EBZ_IDX_BANK]);
        chk(srst, m[`EBZ_IDX_SOFT_RST]);
        // Zone6 unscaled, zone7 doubled, zone0 ready unused
        lk <= 1'b1;
        xfer(1'b1, 16'(Z6 * 4), 32'h000126a8);
        xfer(1'b1, 16'(Z7 * 4), 32'h004326a8);
        xfer(1'b1, 16'(Z0 * 4), 32'h0003a6a8);
        acc(3'h6, 1'b0, 999, ns);
        chk(ns, cyc(m[Z6], 1'b0));
        chk(wide, 1'b1);
        acc(3'h6, 1'b1, 999, ns);
        chk(ns, cyc(m[Z6], 1'b1));
        acc(3'h7, 1'b0, 999, ns);
        chk(ns, cyc(m[Z7], 1'b0));
        chk(wide, 1'b0);
        acc(3'h3, 1'b0, 999, ns);
        chk(ns, cyc(m[Z0], 1'b0));
        // Late ready stretches; async sampling lands a cycle later
        // rewrite only between accesses
        xfer(1'b1, 16'(Z0 * 4), 32'h000366a8);
        acc(3'h0, 1'b0, 12, ns);
        chk(ns > cyc(m[Z0], 1'b0), 1'b1);
        xfer(1'b1, 16'(Z0 * 4), 32'h0003e6a8);
        acc(3'h0, 1'b0, 12, na);
        chk(na, ns + 1);
        finish_test;
    end
endmodule // tb_ebz_config_regs
